// file: sgs_supervisor.sv
// switchgear position supervisor with trip manager and apb slave
//
// Chosen here: the address map and register access over APB.
module sgs_supervisor
    import sgs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 aux_closed,
    input  wire logic                 aux_open,
    input  wire logic [NUM_ILOCK-1:0] ilock_close,
    input  wire logic [NUM_ILOCK-1:0] ilock_open,
    input  wire logic [NUM_TRIP-1:0]  prot_trip,
    input  wire logic                 prot_block,
    input  wire logic                 auto_reclose,
    input  wire logic                 external_close_req,
    input  wire logic                 external_open_req,
    input  wire logic                 trip_ack_input,
    output logic                      close_cmd,
    output logic                      open_cmd,
    output logic                      trip_cmd,
    output logic      [1:0]           pos_code,
    output logic                      pos_closed,
    output logic                      pos_open,
    output logic                      pos_indet,
    output logic                      pos_disturb,
    output logic                      one_contact_flag,
    output logic                      command_success
);
    localparam int NPIN = 2 + 2 * NUM_ILOCK + NUM_TRIP + 5;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] sync3_reg;
    logic [NPIN-1:0] filt_reg;
    logic [NPIN-1:0] pins;

    assign pins = {aux_closed, aux_open, ilock_close, ilock_open, prot_trip,
                   prot_block, auto_reclose, external_close_req, external_open_req,
                   trip_ack_input};

    // a change counts once stages two and three agree; glitches are lost
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg  <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);
        end
    end

    logic                 f_closed;
    logic                 f_open;
    logic [NUM_ILOCK-1:0] f_ilk_close;
    logic [NUM_ILOCK-1:0] f_ilk_open;
    logic [NUM_TRIP-1:0]  f_trip;
    logic                 f_block;
    logic                 f_ar;
    logic                 f_ext_close;
    logic                 f_ext_open;
    logic                 f_ack;

    assign {f_closed, f_open, f_ilk_close, f_ilk_open, f_trip, f_block, f_ar,
            f_ext_close, f_ext_open, f_ack} = filt_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait-free access phase
    logic [4:0]          ctrl_reg;
    logic [15:0]         tclose_reg;
    logic [15:0]         topen_reg;
    logic [15:0]         settle_reg;
    logic [15:0]         thold_reg;
    logic [NUM_TRIP-1:0] tassgn_reg;
    logic [31:0]         status;
    logic [31:0]         rdata_next;
    logic                mapped;
    logic                wr_acc;
    logic                cmd_wr;

    assign wr_acc = psel & penable & pready & pwrite;
    assign cmd_wr = wr_acc & (paddr == OFF_CMD);

    // read mux; unmapped addresses give pslverr
    always_comb begin
        rdata_next = 32'h0000_0000;
        mapped     = 1'b1;
        case (paddr)
            OFF_CTRL:   rdata_next = {27'h0, ctrl_reg};
            OFF_CMD:    rdata_next = 32'h0000_0000;
            OFF_TCLOSE: rdata_next = {16'h0, tclose_reg};
            OFF_TOPEN:  rdata_next = {16'h0, topen_reg};
            OFF_SETTLE: rdata_next = {16'h0, settle_reg};
            OFF_THOLD:  rdata_next = {16'h0, thold_reg};
            OFF_TASSGN: rdata_next = {24'h0, tassgn_reg};
            OFF_STATUS: rdata_next = status;
            default:    mapped = 1'b0;
        endcase
    end

    // answer set in setup; pready in first access cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_next : 32'h0000_0000;
        end
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_reg   <= CTRL_RST;
            tclose_reg <= TRAVEL_RST;
            topen_reg  <= TRAVEL_RST;
            settle_reg <= SETTLE_RST;
            thold_reg  <= THOLD_RST;
            tassgn_reg <= TASSGN_RST;
        end else if (wr_acc) begin
            case (paddr)
                OFF_CTRL:   ctrl_reg   <= pwdata[4:0];
                OFF_TCLOSE: tclose_reg <= pwdata[15:0];
                OFF_TOPEN:  topen_reg  <= pwdata[15:0];
                OFF_SETTLE: settle_reg <= pwdata[15:0];
                OFF_THOLD:  thold_reg  <= pwdata[15:0];
                OFF_TASSGN: tassgn_reg <= pwdata[NUM_TRIP-1:0];
                default:    ;
            endcase
        end
    end

    logic       wired_c;
    logic       wired_o;
    logic [1:0] auth;
    logic       latch_en;

    assign wired_c  = ctrl_reg[CTRL_CLOSED_WIRED];
    assign wired_o  = ctrl_reg[CTRL_OPEN_WIRED];
    assign auth     = ctrl_reg[CTRL_AUTH_LSB+1:CTRL_AUTH_LSB];
    assign latch_en = ctrl_reg[CTRL_LATCH];

    ////////////////////////////////////////////////////////////////////////////
    // timebase tick
    logic [31:0] tick_cnt;
    logic        tick;

    assign tick = (tick_cnt == TICK_CYCLES - 1);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tick_cnt <= 32'h0000_0000; // RULE_25
        end else begin
            tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001; // RULE_25
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trip manager
    logic        trip_any;
    logic        latched_reg;
    logic [15:0] hold_cnt;
    logic        trip_ack;

    assign trip_any = |(f_trip & tassgn_reg) & ~f_block; // RULE_15 RULE_14
    assign trip_ack = (cmd_wr & pwdata[CMD_TRIP_ACK]) | f_ack;

    // set wins over clear
    always_ff @(posedge clock) begin
        if (!resetn) begin
            latched_reg <= 1'b0;
            hold_cnt    <= 16'h0000; // RULE_25
            trip_cmd    <= 1'b0;
        end else begin
            if (trip_any && latch_en) begin
                latched_reg <= 1'b1; // RULE_17 RULE_18
            end else if (!(|(f_trip & tassgn_reg)) &&
                         (trip_ack || !latch_en || tassgn_reg == '0)) begin
                latched_reg <= 1'b0; // RULE_19
            end
            if (trip_any) begin
                hold_cnt <= thold_reg; // RULE_17
            end else if (tick && hold_cnt != 16'h0000) begin
                hold_cnt <= hold_cnt - 16'h0001;
            end
            // combined request only
            trip_cmd <= trip_any | (hold_cnt != 16'h0000) | latched_reg; // RULE_16 RULE_17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request gating
    logic ext_close_d;
    logic loc_ok;
    logic rem_ok;
    logic req_close;
    logic req_open;
    logic prot_open;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ext_close_d <= 1'b0;
        end else begin
            ext_close_d <= f_ext_close;
        end
    end

    assign loc_ok    = (auth == AUTH_LOCAL) | (auth == AUTH_BOTH);
    assign rem_ok    = (auth == AUTH_REMOTE) | (auth == AUTH_BOTH); // RULE_22
    assign prot_open = trip_any;

    // external inputs are remote; open wins
    always_comb begin
        req_open  = ((loc_ok & cmd_wr & pwdata[CMD_LOC_OPEN]) |
                     (rem_ok & cmd_wr & pwdata[CMD_REM_OPEN]) |
                     (rem_ok & f_ext_open)) & ~(|f_ilk_open); // RULE_13 RULE_20 RULE_21 RULE_22
        req_open  = req_open | prot_open; // RULE_14
        req_close = ((loc_ok & cmd_wr & pwdata[CMD_LOC_CLOSE]) |
                     (rem_ok & cmd_wr & pwdata[CMD_REM_CLOSE]) |
                     (rem_ok & f_ext_close & ~ext_close_d)) & ~(|f_ilk_close); // RULE_13 RULE_21
        req_close = (req_close | f_ar) & ~req_open; // RULE_14 RULE_21
    end

    ////////////////////////////////////////////////////////////////////////////
    // travel and settle supervision
    sgs_state_e  state_reg;
    logic [15:0] tmr_cnt;
    logic        settle_closed_reg;
    logic        fail_reg;
    logic        fb_closed;
    logic        fb_open;
    logic        sup_close;
    logic        sup_open;

    assign fb_closed = wired_c ? (f_closed & ~(wired_o & f_open)) : 1'b0;
    assign fb_open   = wired_o ? (f_open & ~(wired_c & f_closed)) : 1'b0;
    assign sup_close = wired_c; // RULE_07
    assign sup_open  = wired_o; // RULE_07

    // one command at a time
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg         <= ST_IDLE;
            tmr_cnt           <= 16'h0000; // RULE_25
            settle_closed_reg <= 1'b0;
            fail_reg          <= 1'b0;
            command_success   <= 1'b0;
            close_cmd         <= 1'b0;
            open_cmd          <= 1'b0;
        end else begin
            if (tick && tmr_cnt != 16'h0000) begin
                tmr_cnt <= tmr_cnt - 16'h0001;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (req_open && !fb_open) begin
                        state_reg       <= ST_OPEN; // RULE_01 RULE_26
                        tmr_cnt         <= topen_reg;
                        open_cmd        <= 1'b1;
                        command_success <= 1'b0;
                        fail_reg        <= 1'b0;
                    end else if (req_close && !fb_closed) begin
                        state_reg       <= ST_CLOSE; // RULE_23 RULE_26
                        tmr_cnt         <= tclose_reg;
                        close_cmd       <= 1'b1;
                        command_success <= 1'b0;
                        fail_reg        <= 1'b0;
                    end
                end
                ST_CLOSE: begin
                    if (fb_closed) begin
                        state_reg       <= ST_IDLE; // RULE_08 RULE_23 RULE_24
                        close_cmd       <= 1'b0;
                        command_success <= 1'b1;
                    end else if (tmr_cnt == 16'h0000) begin
                        close_cmd <= 1'b0; // RULE_24
                        if (sup_close && !wired_o && settle_reg != 16'h0000) begin
                            state_reg         <= ST_SETTLE; // RULE_09
                            tmr_cnt           <= settle_reg;
                            settle_closed_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                            fail_reg  <= sup_close; // RULE_03 RULE_23
                        end
                    end
                end
                ST_OPEN: begin
                    if (fb_open) begin
                        state_reg       <= ST_IDLE; // RULE_02 RULE_11 RULE_24
                        open_cmd        <= 1'b0;
                        command_success <= 1'b1;
                    end else if (tmr_cnt == 16'h0000) begin
                        open_cmd <= 1'b0; // RULE_24
                        if (sup_open && !wired_c && settle_reg != 16'h0000) begin
                            state_reg         <= ST_SETTLE; // RULE_11
                            tmr_cnt           <= settle_reg;
                            settle_closed_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_IDLE;
                            fail_reg  <= sup_open; // RULE_03
                        end
                    end
                end
                ST_SETTLE: begin
                    if (tmr_cnt == 16'h0000) begin
                        state_reg       <= ST_IDLE; // RULE_09 RULE_11
                        command_success <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    close_cmd <= 1'b0;
                    open_cmd  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // position evaluation
    logic       running;
    logic [1:0] code_next;
    logic       settled_done;

    // a failed travel with one contact wired shows disturbed until the next command
    assign running = ((state_reg == ST_CLOSE) && sup_close) ||
                     ((state_reg == ST_OPEN) && sup_open) ||
                     (state_reg == ST_SETTLE);
    assign settled_done = command_success & (settle_reg != 16'h0000);

    always_comb begin
        code_next = POS_DISTURB;
        if (!wired_c && !wired_o) begin
            code_next = POS_DISTURB; // RULE_10 RULE_12
        end else if (running) begin
            code_next = POS_INDET; // RULE_01 RULE_05 RULE_08 RULE_09 RULE_11
        end else if (wired_c && wired_o) begin
            case ({f_closed, f_open})
                2'b01:   code_next = POS_OPEN; // RULE_04
                2'b10:   code_next = POS_CLOSED; // RULE_04
                default: code_next = POS_DISTURB; // RULE_05
            endcase
        end else if (fail_reg) begin
            code_next = POS_DISTURB; // RULE_03
        end else if (wired_c) begin
            code_next = (f_closed || (settled_done && settle_closed_reg)) ? POS_CLOSED : POS_OPEN;
        end else begin
            code_next = (f_open || (settled_done && !settle_closed_reg)) ? POS_OPEN : POS_CLOSED;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pos_code         <= POS_DISTURB;
            pos_closed       <= 1'b0;
            pos_open         <= 1'b0;
            pos_indet        <= 1'b0;
            pos_disturb      <= 1'b1;
            one_contact_flag <= 1'b0;
        end else begin
            pos_code         <= code_next;
            pos_closed       <= (code_next == POS_CLOSED);
            pos_open         <= (code_next == POS_OPEN);
            pos_indet        <= (code_next == POS_INDET);
            pos_disturb      <= (code_next == POS_DISTURB);
            one_contact_flag <= wired_c ^ wired_o; // RULE_06
        end
    end

    assign status = {16'h0, state_reg, latched_reg, trip_cmd, open_cmd, close_cmd,
                     command_success, one_contact_flag, pos_disturb, pos_indet,
                     pos_open, pos_closed, pos_code};
endmodule : sgs_supervisor

// file: sgs_pkg.sv
// constants and codes of the supervisor
// Notes on behaviour
// RULE_01: open starts open timer; indeterminate meanwhile
// RULE_02: open feedback in time: open, no indeterminate
// RULE_03: expiry without feedback: disturbed
// RULE_04: 0/1 is open code 1, 1/0 closed code 2
// RULE_05: equal contacts: indeterminate timing, else disturbed
// RULE_06: one contact raises its flag
// RULE_07: one contact supervises its own direction
// RULE_08: closed-only: close timed; closed gives success
// RULE_09: closed-only: settle shows indeterminate, then closed
// RULE_10: no closed contact: code 3
// RULE_11: open-only: open timed; open or settle end gives success
// RULE_12: no open contact: code 3
// RULE_13: three interlocks per direction; any one blocks
// RULE_14: trip open, auto reclose skip interlocks; input blocks trips
// RULE_15: trip request ORs assigned slots
// RULE_16: only combined trip drives the breaker
// RULE_17: trip held a minimum time; a bit latches
// RULE_18: latched trip stays until acknowledged
// RULE_19: latch clears, inputs idle, on ack, unlatch or no slots
// RULE_20: one external close, one external open
// RULE_21: open wins; close on edge, open on level
// RULE_22: remote needs authority remote or both
// RULE_23: close timed; closed on feedback, else disturbed
// RULE_24: relays last at most travel time
// RULE_25: timers count ticks, clear on reset
// RULE_26: one command at a time
package sgs_pkg;
    // timebase
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TICK_TIME_NS    = 1000000;
    localparam int unsigned TICK_CYCLES_DEF = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CMD    = 8'h04;
    localparam logic [7:0] OFF_TCLOSE = 8'h08;
    localparam logic [7:0] OFF_TOPEN  = 8'h0C;
    localparam logic [7:0] OFF_SETTLE = 8'h10;
    localparam logic [7:0] OFF_THOLD  = 8'h14;
    localparam logic [7:0] OFF_TASSGN = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;

    // control fields
    localparam int CTRL_CLOSED_WIRED = 0;
    localparam int CTRL_OPEN_WIRED   = 1;
    localparam int CTRL_AUTH_LSB     = 2;
    localparam int CTRL_LATCH        = 4;
    // command fields, write one to act
    localparam int CMD_LOC_CLOSE = 0;
    localparam int CMD_LOC_OPEN  = 1;
    localparam int CMD_REM_CLOSE = 2;
    localparam int CMD_REM_OPEN  = 3;
    localparam int CMD_TRIP_ACK  = 4;

    // switching authority codes
    localparam logic [1:0] AUTH_NONE   = 2'h0;
    localparam logic [1:0] AUTH_LOCAL  = 2'h1;
    localparam logic [1:0] AUTH_REMOTE = 2'h2;
    localparam logic [1:0] AUTH_BOTH   = 2'h3;

    // position codes
    localparam logic [1:0] POS_INDET   = 2'h0;
    localparam logic [1:0] POS_OPEN    = 2'h1;
    localparam logic [1:0] POS_CLOSED  = 2'h2;
    localparam logic [1:0] POS_DISTURB = 2'h3;

    // reset values
    localparam logic [4:0]  CTRL_RST   = 5'h03;
    localparam logic [15:0] TRAVEL_RST = 16'h0064;
    localparam logic [15:0] SETTLE_RST = 16'h0000;
    localparam logic [15:0] THOLD_RST  = 16'h0064;
    localparam logic [7:0]  TASSGN_RST = 8'h00;

    localparam int NUM_ILOCK = 3;
    localparam int NUM_TRIP  = 8;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_CLOSE  = 4'b0010,
        ST_OPEN   = 4'b0100,
        ST_SETTLE = 4'b1000
    } sgs_state_e;
endpackage : sgs_pkg

// file: sgs_breaker_model.sv
// breaker model: contacts follow the relays after a delay
module sgs_breaker_model #(
    parameter int DLY = 20
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic close_cmd,
    input  wire logic open_cmd,
    input  wire logic stuck,
    output logic      aux_closed,
    output logic      aux_open
);
    logic       closed_reg;
    logic [7:0] move_reg;
    // arm starts open; a jam holds it mid-travel
    always_ff @(posedge clock) begin
        if (!resetn) begin
            closed_reg <= 1'b0;
            move_reg   <= 8'h00;
        end else if (move_reg != 8'h00) begin
            if (!stuck) move_reg <= move_reg - 8'h01;
            if (!stuck && move_reg == 8'h01) closed_reg <= ~closed_reg;
        end else if ((close_cmd && !closed_reg) || (open_cmd && closed_reg)) begin
            move_reg <= 8'(DLY);
        end
    end
    // both contacts low in travel
    assign aux_closed = closed_reg && move_reg == 8'h00;
    assign aux_open   = !closed_reg && move_reg == 8'h00;
endmodule : sgs_breaker_model

// file: sgs_supervisor_sva.sv
// concurrent checks on the supervisor ports
module sgs_supervisor_sva
    import sgs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic                clock,
    input wire logic                resetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [NUM_TRIP-1:0] prot_trip,
    input wire logic                close_cmd,
    input wire logic                open_cmd,
    input wire logic                trip_cmd,
    input wire logic [1:0]          pos_code,
    input wire logic                pos_closed,
    input wire logic                pos_open,
    input wire logic                pos_indet,
    input wire logic                pos_disturb,
    input wire logic                one_contact_flag,
    input wire logic                command_success
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // bound from reset travel value; shorter settings fit
    localparam int MAXC = 101 * TICK_CYCLES + 4;
    logic [15:0] run_cnt_reg;
    logic [7:0]  trip_hist_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // relay run length and trip input history
    always_ff @(posedge clock) begin
        if (!resetn || !(close_cmd || open_cmd)) run_cnt_reg <= 16'h0000;
        else run_cnt_reg <= run_cnt_reg + 16'h0001;
    end
    always_ff @(posedge clock) begin
        if (!resetn) trip_hist_reg <= 8'h00;
        else trip_hist_reg <= {trip_hist_reg[6:0], |prot_trip};
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence trip_run_s;
        trip_cmd [*8];
    endsequence
    apb_ready_a: assert property (setup_s |=> pready) else $error("no ready after setup");
    err_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray error");
    pos_dec_a: assert property ({pos_disturb, pos_closed, pos_open, pos_indet} == 4'h1 << pos_code)
        else $error("flags disagree with code");
    cmd_excl_a: assert property (!(close_cmd && open_cmd)) else $error("two commands");
    close_end_a: assert property (pos_closed && !one_contact_flag |-> !close_cmd)
        else $error("close relay held at closed");
    open_end_a: assert property (pos_open && !one_contact_flag |-> !open_cmd)
        else $error("open relay held at open");
    cmd_len_a: assert property (run_cnt_reg <= MAXC) else $error("relay run too long");
    succ_pos_a: assert property ($rose(command_success) |-> ##[0:2] (pos_closed || pos_open))
        else $error("success without end position");
    indet_run_a: assert property ($rose(close_cmd) && !one_contact_flag |-> ##[0:2] pos_indet)
        else $error("no indet in travel");
    trip_src_a: assert property ($rose(trip_cmd) |-> |trip_hist_reg)
        else $error("trip without request");
    trip_hold_a: assert property ($rose(trip_cmd) |-> trip_run_s) else $error("trip too short");
endmodule : sgs_supervisor_sva

bind sgs_supervisor sgs_supervisor_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (.*);

// file: sgs_supervisor_tb.sv
// self-checking bench for the supervisor
module sgs_supervisor_tb import sgs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic                 pwrite = 1'b0, stuck = 1'b0, prot_block = 1'b0, auto_reclose = 1'b0;
    logic                 external_close_req = 1'b0, external_open_req = 1'b0, trip_ack_input = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0, prdata, rd_data;
    logic [NUM_ILOCK-1:0] ilock_close = 3'h0, ilock_open = 3'h0;
    logic [NUM_TRIP-1:0]  prot_trip = 8'h00;
    logic [1:0]           pos_code;
    logic                 pready, pslverr, rd_err, aux_closed, aux_open, close_cmd, open_cmd;
    logic                 trip_cmd, pos_closed, pos_open, pos_indet, pos_disturb;
    logic                 one_contact_flag, command_success;
    int                   failures = 0, samples_checked = 0;

    sgs_supervisor #(.TICK_CYCLES(4)) i_dut (.*);
    sgs_breaker_model i_brk (.*);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        {rd_data, rd_err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic wait_code(input logic [1:0] c);
        for (int i = 0; i < 300 && pos_code !== c; i++) @(posedge clock);
    endtask : wait_code
    task automatic results();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    // reset values, bad address, close with refused overlap
    task automatic t_close();
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd_data, 32'h3);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd_err, 1'b1);
        wait_code(POS_OPEN);
        chk(pos_code, POS_OPEN);
        apb(1'b1, OFF_TCLOSE, 32'h14);
        apb(1'b1, OFF_TOPEN, 32'h14);
        apb(1'b1, OFF_CTRL, 32'h7);
        apb(1'b1, OFF_CMD, 32'h1);
        cyc(3);
        chk(pos_code, POS_INDET);
        apb(1'b1, OFF_CMD, 32'h2);
        chk(open_cmd, 1'b0);
        wait_code(POS_CLOSED);
        chk({close_cmd, command_success}, 2'h1);
    endtask : t_close
    // refusals; pins need four cycles through the synchroniser
    task automatic t_gate();
        ilock_open <= 3'h4;
        cyc(5);
        apb(1'b1, OFF_CMD, 32'h2);
        cyc(4);
        chk(open_cmd, 1'b0);
        ilock_open <= 3'h0;
        cyc(5);
        apb(1'b1, OFF_CMD, 32'h8);
        cyc(4);
        chk(open_cmd, 1'b0);
        apb(1'b1, OFF_CTRL, 32'hB);
        external_open_req <= 1'b1;
        wait_code(POS_OPEN);
        chk(command_success, 1'b1);
        external_open_req  <= 1'b0;
        external_close_req <= 1'b1;
        wait_code(POS_CLOSED);
        chk(pos_code, POS_CLOSED);
        apb(1'b1, OFF_CMD, 32'h8);
        cyc(120);
        chk(pos_code, POS_OPEN);
        external_close_req <= 1'b0;
    endtask : t_gate
    // jam gives disturbed; wiring choices
    task automatic t_jam();
        stuck <= 1'b1;
        apb(1'b1, OFF_CMD, 32'h4);
        cyc(4);
        chk(pos_code, POS_INDET);
        for (int i = 0; i < 200 && close_cmd !== 1'b0; i++) @(posedge clock);
        cyc(4);
        chk(pos_code, POS_DISTURB);
        stuck <= 1'b0;
        wait_code(POS_CLOSED);
        apb(1'b1, OFF_CTRL, 32'h9);
        cyc(6);
        chk(one_contact_flag, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h8);
        cyc(6);
        chk(pos_code, POS_DISTURB);
    endtask : t_jam
    // trip slots, bypass, latch, ack
    task automatic t_trip();
        apb(1'b1, OFF_THOLD, 32'h3);
        apb(1'b1, OFF_TASSGN, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h1B);
        ilock_open <= 3'h7;
        prot_trip  <= 8'h02;
        cyc(20);
        chk(trip_cmd, 1'b0);
        prot_trip <= 8'h01;
        cyc(10);
        chk(trip_cmd, 1'b1);
        prot_trip <= 8'h00;
        wait_code(POS_OPEN);
        chk(pos_code, POS_OPEN);
        cyc(60);
        chk(trip_cmd, 1'b1);
        trip_ack_input <= 1'b1;
        cyc(8);
        chk(trip_cmd, 1'b0);
        {trip_ack_input, ilock_open} <= 4'h0;
    endtask : t_trip
    ////////////////////////////////////////////////////////////////////////////////
    // main and watchdog
    initial begin
        cyc(3);
        chk(pos_code, POS_DISTURB);
        resetn <= 1'b1;
        t_close();
        t_gate();
        t_jam();
        t_trip();
        results();
    end
    initial begin
        cyc(20000);
        failures++;
        results();
    end
endmodule : sgs_supervisor_tb
